// ==== dv/pbe_pin_src.sv ====
`timescale 1ns/10ps
module pbe_pin_src (
  input wire logic clk_sys,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOeN,
  input wire logic [7:0] pullupOn,
  input wire logic [7:0] srcLevel,
  input wire logic [7:0] srcEn,
  output logic [7:0] pinLevel
);
  logic [7:0] floatPat = 8'h55;
  // An undriven pin keeps moving so a missing pull-up cannot hide.
  always @(posedge clk_sys) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pinOeN[i]) pinLevel[i] = pinOut[i];
      else if (srcEn[i]) pinLevel[i] = srcLevel[i];
      else if (pullupOn[i]) pinLevel[i] = 1'b1;
      else pinLevel[i] = floatPat[i];
    end
  end
endmodule

// ==== dv/pbe_port_b_checker.sv ====
`timescale 1ns/10ps
module pbe_port_b_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire pbe_pkg::pbe_bus_req_t busReq,
  input wire logic [7:0] rdData,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOeN,
  input wire logic [7:0] pullupOn,
  input wire logic sleepActive,
  input wire logic capture2PinSelect,
  input wire logic capture2OutEn,
  input wire logic capture2Out,
  input wire logic capture2In,
  input wire pbe_pkg::pbe_irq_out_t irqOut
);
  // Timing figures assume the clock enable stays high, as the bench holds it.
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  property p_rstState;
    $rose(rst_b) |-> pinOeN == 8'hff && pullupOn == 8'h00;
  endproperty
  a_rstState: assert property (p_rstState) else $error("reset state wrong");
  property p_dirWrite;
    busReq.wrStb && busReq.addr == pbe_pkg::ADDR_DIR && capture2PinSelect
      |=> pinOeN == $past(busReq.wrData);
  endproperty
  a_dirWrite: assert property (p_dirWrite) else $error("direction not applied");
  property p_pullOff;
    (pullupOn & ~pinOeN) == 8'h00;
  endproperty
  a_pullOff: assert property (p_pullOff) else $error("pull-up on output");
  property p_latchRead;
    busReq.wrStb && busReq.addr == pbe_pkg::ADDR_LATCH ##1 !busReq.wrStb
      ##1 busReq.rdStb && busReq.addr == pbe_pkg::ADDR_LATCH
      |=> rdData == $past(busReq.wrData, 3);
  endproperty
  a_latchRead: assert property (p_latchRead) else $error("latch readback wrong");
  property p_wakeSleep;
    irqOut.wakeReq |-> sleepActive;
  endproperty
  a_wakeSleep: assert property (p_wakeSleep) else $error("wake while awake");
  property p_wakeSplit;
    irqOut.branchToVector || irqOut.resumeNext
      |-> irqOut.wakeReq && (irqOut.branchToVector != irqOut.resumeNext);
  endproperty
  a_wakeSplit: assert property (p_wakeSplit) else $error("wake split wrong");
  property p_capSync;
    !capture2PinSelect && $past(rst_b, 2) |-> capture2In == $past(pinIn[3], 2);
  endproperty
  a_capSync: assert property (p_capSync) else $error("capture input wrong");
  property p_capOwn;
    !capture2PinSelect && capture2OutEn |-> !pinOeN[3] && pinOut[3] == capture2Out;
  endproperty
  a_capOwn: assert property (p_capOwn) else $error("capture drive wrong");
  c_wake: cover property (irqOut.wakeReq && irqOut.branchToVector);
  c_latch: cover property (busReq.wrStb && busReq.addr == pbe_pkg::ADDR_LATCH);
  c_cap: cover property (!capture2PinSelect && capture2In);
endmodule

bind pbe_port_b pbe_port_b_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .busReq(busReq), .rdData(rdData), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
  .pullupOn(pullupOn), .sleepActive(sleepActive), .capture2PinSelect(capture2PinSelect),
  .capture2OutEn(capture2OutEn), .capture2Out(capture2Out), .capture2In(capture2In),
  .irqOut(irqOut));

// ==== dv/tb_port_b_edge_and_change_irq.sv ====
`timescale 1ns/10ps
module tb_port_b_edge_and_change_irq;
  localparam logic [2:0] PORT = pbe_pkg::ADDR_PORT;
  localparam logic [2:0] MAIN = pbe_pkg::ADDR_CTRL_MAIN;
  localparam logic [2:0] SEC = pbe_pkg::ADDR_CTRL_SECOND;
  localparam logic [2:0] THR = pbe_pkg::ADDR_CTRL_THIRD;
  logic clk_sys, rst_b, memMove, sleepActive, capSel, capOut, capOutEn, capIn;
  pbe_pkg::pbe_bus_req_t req;
  pbe_pkg::pbe_irq_out_t irq;
  logic [7:0] rdData, pinLevel, pinOut, pinOeN, pullupOn, srcLevel, srcEn;
  int failures = 0;
  int nChecks = 0;
  pbe_port_b DUT (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1), .busReq(req),
    .memMoveAccess(memMove), .rdData(rdData), .pinIn(pinLevel), .pinOut(pinOut),
    .pinOeN(pinOeN), .pullupOn(pullupOn), .sleepActive(sleepActive),
    .capture2PinSelect(capSel), .capture2Out(capOut), .capture2OutEn(capOutEn),
    .capture2In(capIn), .irqOut(irq));
  pbe_pin_src u_src (.clk_sys(clk_sys), .pinOut(pinOut), .pinOeN(pinOeN),
    .pullupOn(pullupOn), .srcLevel(srcLevel), .srcEn(srcEn), .pinLevel(pinLevel));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wrStb <= 1'b0;
    #1;
  endtask
  task automatic rcm(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rdStb <= 1'b0;
    #1;
    chk(rdData & m, e);
  endtask
  task automatic setPin(input int i, input logic v);
    @(posedge clk_sys);
    srcLevel[i] <= v;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_reset;
    rcm(pbe_pkg::ADDR_DIR, 8'hff, 8'hff);
    rcm(SEC, 8'h80, 8'h80);
    chk(pullupOn, 8'h00);
    rcm(3'h6, 8'hff, 8'h00);
  endtask
  task automatic t_latch;
    srcLevel <= 8'h38;
    wr(pbe_pkg::ADDR_LATCH, 8'ha5);
    rcm(pbe_pkg::ADDR_LATCH, 8'hff, 8'ha5);
    rcm(PORT, 8'hff, 8'h38);
    wr(pbe_pkg::ADDR_DIR, 8'hf0);
    wr(SEC, 8'h71);
    chk(pullupOn, 8'hf0);
    rcm(PORT, 8'h0f, 8'h05);
    wr(SEC, 8'hf1);
    wr(pbe_pkg::ADDR_DIR, 8'hff);
  endtask
  task automatic t_edges;
    logic [2:0] r;
    logic [7:0] m;
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        r = (i == 0) ? MAIN : THR;
        m = (i == 0) ? 8'h02 : 8'h01 << (i - 1);
        wr(SEC, 8'h81 | (8'(p) << (6 - i)));
        setPin(i, p[0]);
        wr(MAIN, 8'h00);
        wr(THR, 8'hc0);
        setPin(i, !p[0]);
        rcm(r, m, 8'h00);
        setPin(i, p[0]);
        rcm(r, m, m);
      end
    end
  endtask
  task automatic t_irq;
    wr(MAIN, 8'h80);
    wr(THR, 8'h92);
    chk({6'h0, irq.irqHigh, irq.irqLow}, 8'h02);
    wr(THR, 8'h12);
    chk({6'h0, irq.irqHigh, irq.irqLow}, 8'h01);
    wr(THR, 8'h02);
    chk({6'h0, irq.irqHigh, irq.irqLow}, 8'h00);
    rcm(THR, 8'h02, 8'h02);
    wr(MAIN, 8'h90);
    @(posedge clk_sys);
    sleepActive <= 1'b1;
    setPin(0, 1'b0);
    chk({5'h0, irq.wakeReq, irq.branchToVector, irq.resumeNext}, 8'h06);
    chk({7'h0, irq.irqHigh}, 8'h01);
    wr(MAIN, 8'h12);
    chk({5'h0, irq.wakeReq, irq.branchToVector, irq.resumeNext}, 8'h05);
    sleepActive <= 1'b0;
  endtask
  task automatic t_change;
    rcm(PORT, 8'h00, 8'h00);
    wr(MAIN, 8'h00);
    setPin(3, 1'b0);
    rcm(MAIN, 8'h01, 8'h00);
    setPin(6, 1'b1);
    rcm(MAIN, 8'h01, 8'h01);
    wr(MAIN, 8'h88);
    rcm(MAIN, 8'h01, 8'h01);
    chk({6'h0, irq.irqHigh, irq.irqLow}, 8'h02);
    wr(SEC, 8'hf0);
    chk({6'h0, irq.irqHigh, irq.irqLow}, 8'h01);
    memMove <= 1'b1;
    rcm(PORT, 8'h00, 8'h00);
    memMove <= 1'b0;
    wr(MAIN, 8'h88);
    rcm(MAIN, 8'h01, 8'h01);
    rcm(PORT, 8'h00, 8'h00);
    wr(MAIN, 8'h88);
    rcm(MAIN, 8'h01, 8'h00);
    wr(pbe_pkg::ADDR_DIR, 8'hef);
    setPin(4, 1'b1);
    rcm(MAIN, 8'h01, 8'h00);
  endtask
  task automatic t_cap;
    capSel <= 1'b0;
    capOutEn <= 1'b1;
    capOut <= 1'b1;
    setPin(7, 1'b0);
    chk({5'h0, pinOut[3], pinOeN[3], capIn}, 8'h05);
  endtask
  task automatic stop_test;
    $display("checks=%0d failures=%0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    {memMove, sleepActive, capOut, capOutEn} = 4'h0;
    capSel = 1'b1;
    srcLevel = 8'h00;
    srcEn = 8'hff;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_latch();
    t_edges();
    t_irq();
    t_change();
    t_cap();
    stop_test();
  end
  // A hang counts as a mismatch instead of stalling the run.
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    stop_test();
  end
endmodule

// ==== rtl/pbe_pkg.sv ====
package pbe_pkg;

  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_PORT = 3'h0;
  localparam logic [2:0] ADDR_LATCH = 3'h1;
  localparam logic [2:0] ADDR_DIR = 3'h2;
  localparam logic [2:0] ADDR_CTRL_MAIN = 3'h3;
  localparam logic [2:0] ADDR_CTRL_SECOND = 3'h4;
  localparam logic [2:0] ADDR_CTRL_THIRD = 3'h5;

  // Main control register fields.
  localparam int MAIN_GIE = 7;
  localparam int MAIN_EXT0_EN = 4;
  localparam int MAIN_CHG_EN = 3;
  localparam int MAIN_EXT0_FLAG = 1;
  localparam int MAIN_CHG_FLAG = 0;

  // Second control register fields.
  localparam int SEC_PULLUP_N = 7;
  localparam int SEC_EDGE0 = 6;
  localparam int SEC_EDGE1 = 5;
  localparam int SEC_EDGE2 = 4;
  localparam int SEC_CHG_PRIO = 0;

  // Third control register fields.
  localparam int THR_EXT2_PRIO = 7;
  localparam int THR_EXT1_PRIO = 6;
  localparam int THR_EXT2_EN = 4;
  localparam int THR_EXT1_EN = 3;
  localparam int THR_EXT2_FLAG = 1;
  localparam int THR_EXT1_FLAG = 0;

  // Values after reset.
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_SECOND = 8'hf1;
  localparam logic [7:0] RST_THIRD = 8'hc0;
  localparam logic [7:0] RST_PINS = 8'h00;
  // Enabled edges after reset before the pin history holds real pin levels.
  localparam logic [1:0] WARM_CYCLES = 2'h3;

  // Mask of pins that take part in change detection.
  localparam logic [7:0] CHG_PIN_MASK = 8'hf0;
  localparam int CAPTURE2_PIN = 3;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } pbe_bus_req_t;

  typedef struct packed {
    logic irqHigh;
    logic irqLow;
    logic wakeReq;
    logic branchToVector;
    logic resumeNext;
  } pbe_irq_out_t;

endpackage

// ==== rtl/pbe_port_b.sv ====
// Operation
// - Edge select one catches rising edges, zero catches falling edges.
// - A selected edge on an external pin sets that pin's flag.
// - Clearing an enable stops requests; the flag still records edges.
// - External interrupts wake from sleep if enabled before sleep began.
// - After wake, branch to vector when global enable set, else continue.
// - Priorities of external sources one and two are third-control bits 6, 7.
// - External source zero has no priority bit and is always high.
// - Direction one makes pin an input; zero drives latch onto pin.
// - Reset makes all eight pins inputs.
// - Output latch is mapped and reads back latch, not pins.
// - Clearing second-control bit 7 turns on all weak pull-ups.
// - Pull-up is off on any pin configured as output.
// - Reset leaves pull-ups disabled.
// - Only upper four input pins take part in change detection.
// - Each such pin is compared with its value at last port read or write.
// - Mismatches are ORed to set main-control bit 0 change flag.
// - Change enable is main bit 3; its priority second bit 0.
// - The change interrupt can wake the device from sleep.
// - Any port read or write refreshes the copy, except memory moves.
// - A lasting mismatch keeps setting the change flag.
// - Pin 3 serves capture module two when its select bit is zero.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
module pbe_port_b (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire pbe_pkg::pbe_bus_req_t busReq,
  input wire logic memMoveAccess,
  output logic [7:0] rdData,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOeN,
  output logic [7:0] pullupOn,
  input wire logic sleepActive,
  input wire logic capture2PinSelect,
  input wire logic capture2Out,
  input wire logic capture2OutEn,
  output logic capture2In,
  output pbe_pkg::pbe_irq_out_t irqOut
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic edgeSeen(input logic prev, input logic cur,
                                    input logic rising);
    edgeSeen = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and previous sample.

  logic [7:0] pinMeta;
  logic [7:0] pinSync;
  logic [7:0] pinPrev;
  logic [7:0] next_pinMeta;
  logic [7:0] next_pinSync;
  logic [7:0] next_pinPrev;
  logic [1:0] warmCnt;
  logic [1:0] next_warmCnt;
  logic primed;

  // The history resets to zero while a pin may idle high, so edges and
  // mismatches are ignored until real samples have filled every stage.
  assign primed = warmCnt == pbe_pkg::WARM_CYCLES;

  always_comb begin
    next_pinMeta = pinMeta;
    next_pinSync = pinSync;
    next_pinPrev = pinPrev;
    next_warmCnt = warmCnt;
    if (clkEn) begin
      if (!primed) begin
        next_warmCnt = 2'(warmCnt + 2'h1);
      end
      next_pinMeta = pinIn;
      next_pinSync = pinMeta;
      next_pinPrev = pinSync;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta <= pbe_pkg::RST_PINS;
      pinSync <= pbe_pkg::RST_PINS;
      pinPrev <= pbe_pkg::RST_PINS;
      warmCnt <= 2'h0;
    end else begin
      warmCnt <= next_warmCnt;
      pinMeta <= next_pinMeta;
      pinSync <= next_pinSync;
      pinPrev <= next_pinPrev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file, flags and change detection.

  logic [7:0] latchReg;
  logic [7:0] dirReg;
  logic [7:0] ctrlMain;
  logic [7:0] ctrlSecond;
  logic [7:0] ctrlThird;
  logic [7:0] portCopy;
  logic [7:0] next_latchReg;
  logic [7:0] next_dirReg;
  logic [7:0] next_ctrlMain;
  logic [7:0] next_ctrlSecond;
  logic [7:0] next_ctrlThird;
  logic [7:0] next_portCopy;
  logic [7:0] next_rdData;
  logic [7:0] portView;
  logic [7:0] mismatch;
  logic [2:0] extEdge;
  logic chgSet;
  logic portAccess;
  logic wrMain;
  logic wrThird;

  // Pin 3 reads back capture two's output when that module owns the pin and its output is enabled.
  logic capOwnsPin;
  assign capOwnsPin = !capture2PinSelect;

  always_comb begin
    portView = pinSync;
    if (capOwnsPin && capture2OutEn) begin
      portView[pbe_pkg::CAPTURE2_PIN] = capture2Out;
    end
  end

  always_comb begin
    extEdge[0] = primed && edgeSeen(pinPrev[0], pinSync[0],
                                    ctrlSecond[pbe_pkg::SEC_EDGE0]);
    extEdge[1] = primed && edgeSeen(pinPrev[1], pinSync[1],
                                    ctrlSecond[pbe_pkg::SEC_EDGE1]);
    extEdge[2] = primed && edgeSeen(pinPrev[2], pinSync[2],
                                    ctrlSecond[pbe_pkg::SEC_EDGE2]);
    mismatch = (pinSync ^ portCopy) & dirReg & pbe_pkg::CHG_PIN_MASK;
    chgSet = primed && |mismatch;
  end

  // Memory-to-memory moves leave the compare copy alone, so a move can be
  // used to sample the port without acknowledging a pending change.
  always_comb begin
    portAccess = (busReq.rdStb || busReq.wrStb) &&
                 busReq.addr == pbe_pkg::ADDR_PORT && !memMoveAccess;
    wrMain = busReq.wrStb && busReq.addr == pbe_pkg::ADDR_CTRL_MAIN;
    wrThird = busReq.wrStb && busReq.addr == pbe_pkg::ADDR_CTRL_THIRD;
  end

  always_comb begin
    next_latchReg = latchReg;
    next_dirReg = dirReg;
    next_ctrlMain = ctrlMain;
    next_ctrlSecond = ctrlSecond;
    next_ctrlThird = ctrlThird;
    next_portCopy = portCopy;
    next_rdData = 8'h00;
    if (clkEn) begin
      if (busReq.wrStb) begin
        if (busReq.addr == pbe_pkg::ADDR_PORT) begin
          next_latchReg = busReq.wrData;
        end else if (busReq.addr == pbe_pkg::ADDR_LATCH) begin
          next_latchReg = busReq.wrData;
        end else if (busReq.addr == pbe_pkg::ADDR_DIR) begin
          next_dirReg = busReq.wrData;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_MAIN) begin
          next_ctrlMain = busReq.wrData;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_SECOND) begin
          next_ctrlSecond = busReq.wrData;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_THIRD) begin
          next_ctrlThird = busReq.wrData;
        end
      end
      if (busReq.rdStb) begin
        if (busReq.addr == pbe_pkg::ADDR_PORT) begin
          next_rdData = portView;
        end else if (busReq.addr == pbe_pkg::ADDR_LATCH) begin
          next_rdData = latchReg;
        end else if (busReq.addr == pbe_pkg::ADDR_DIR) begin
          next_rdData = dirReg;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_MAIN) begin
          next_rdData = ctrlMain;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_SECOND) begin
          next_rdData = ctrlSecond;
        end else if (busReq.addr == pbe_pkg::ADDR_CTRL_THIRD) begin
          next_rdData = ctrlThird;
        end
      end
      if (portAccess || !primed) begin
        next_portCopy = pinSync;
      end
      // Hardware sets win over a software clear in the same cycle.
      if (extEdge[0]) begin
        next_ctrlMain[pbe_pkg::MAIN_EXT0_FLAG] = 1'b1;
      end
      if (chgSet) begin
        next_ctrlMain[pbe_pkg::MAIN_CHG_FLAG] = 1'b1;
      end
      if (extEdge[1]) begin
        next_ctrlThird[pbe_pkg::THR_EXT1_FLAG] = 1'b1;
      end
      if (extEdge[2]) begin
        next_ctrlThird[pbe_pkg::THR_EXT2_FLAG] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      latchReg <= pbe_pkg::RST_LATCH;
      dirReg <= pbe_pkg::RST_DIR;
      ctrlMain <= pbe_pkg::RST_MAIN;
      ctrlSecond <= pbe_pkg::RST_SECOND;
      ctrlThird <= pbe_pkg::RST_THIRD;
      portCopy <= pbe_pkg::RST_PINS;
      rdData <= 8'h00;
    end else begin
      latchReg <= next_latchReg;
      dirReg <= next_dirReg;
      ctrlMain <= next_ctrlMain;
      ctrlSecond <= next_ctrlSecond;
      ctrlThird <= next_ctrlThird;
      portCopy <= next_portCopy;
      rdData <= next_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers and pull-ups.

  always_comb begin
    pinOut = latchReg;
    pinOeN = dirReg;
    if (capOwnsPin && capture2OutEn) begin
      pinOut[pbe_pkg::CAPTURE2_PIN] = capture2Out;
      pinOeN[pbe_pkg::CAPTURE2_PIN] = 1'b0;
    end
    // An output pin never keeps its pull-up, whatever the control bit says.
    pullupOn = {8{!ctrlSecond[pbe_pkg::SEC_PULLUP_N]}} & pinOeN;
    capture2In = capOwnsPin ? pinSync[pbe_pkg::CAPTURE2_PIN] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep snapshot of enables and interrupt outputs.

  logic [3:0] enAtSleep;
  logic sleepSeen;
  logic [3:0] next_enAtSleep;
  logic next_sleepSeen;
  logic [3:0] liveEn;
  logic [3:0] liveFlag;
  logic [3:0] highPrio;
  logic [3:0] pending;
  logic wakeNow;

  // Order of the four sources: change, ext zero, ext one, ext two.
  always_comb begin
    liveEn = {ctrlThird[pbe_pkg::THR_EXT2_EN], ctrlThird[pbe_pkg::THR_EXT1_EN],
              ctrlMain[pbe_pkg::MAIN_EXT0_EN], ctrlMain[pbe_pkg::MAIN_CHG_EN]};
    liveFlag = {ctrlThird[pbe_pkg::THR_EXT2_FLAG], ctrlThird[pbe_pkg::THR_EXT1_FLAG],
                ctrlMain[pbe_pkg::MAIN_EXT0_FLAG], ctrlMain[pbe_pkg::MAIN_CHG_FLAG]};
    highPrio = {ctrlThird[pbe_pkg::THR_EXT2_PRIO], ctrlThird[pbe_pkg::THR_EXT1_PRIO],
                1'b1,
                ctrlSecond[pbe_pkg::SEC_CHG_PRIO]};
    pending = liveFlag & liveEn;
  end

  // Enables are frozen on entry to sleep; one set later cannot wake the core.
  always_comb begin
    next_enAtSleep = enAtSleep;
    next_sleepSeen = sleepSeen;
    if (clkEn) begin
      next_sleepSeen = sleepActive;
      if (sleepActive && !sleepSeen) begin
        next_enAtSleep = liveEn;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enAtSleep <= 4'h0;
      sleepSeen <= 1'b0;
    end else begin
      enAtSleep <= next_enAtSleep;
      sleepSeen <= next_sleepSeen;
    end
  end

  always_comb begin
    // Wake only while the core still sleeps; the registered copy lags a cycle.
    wakeNow = sleepActive && sleepSeen && |(liveFlag & enAtSleep & liveEn);
    irqOut.irqHigh = ctrlMain[pbe_pkg::MAIN_GIE] && |(pending & highPrio);
    irqOut.irqLow = ctrlMain[pbe_pkg::MAIN_GIE] && |(pending & ~highPrio);
    irqOut.wakeReq = wakeNow;
    irqOut.branchToVector = wakeNow && ctrlMain[pbe_pkg::MAIN_GIE];
    irqOut.resumeNext = wakeNow && !ctrlMain[pbe_pkg::MAIN_GIE];
  end

endmodule
